// ### emu_pkg.sv
// Shared constants and types for the emulation-mode and reset-pin block.
// Assumes a single 10 MHz clock and synchronous pin inputs.
package emu_pkg;

  // Clock period, for converting documented times into cycles
  localparam int unsigned CLK_PERIOD_NS = 100;

  // Bus cycle length of an externally mapped port access, in clocks
  localparam logic [1:0] PORT_ACCESS_CYCLES = 2'h3;

  // Mode-select pin positions on the data bus
  localparam int unsigned MODE_LINE_ONE_POS = 1;
  localparam int unsigned MODE_LINE_TEN_POS = 10;
  localparam int unsigned MODE_LINE_THIRTEEN_POS = 13;

  // Bus and pin widths
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned CS_W = 11;
  localparam int unsigned PWM_W = 2;

  // Port register window
  localparam logic [23:0] PORT_WIN_BASE = 24'hFFF000;
  localparam logic [23:0] PORT_WIN_MASK = 24'hFFFF00;

  // Port register offsets within the window, mapped out in emulator mode
  localparam logic [7:0] PORT_A_DATA_OFS = 8'h10;
  localparam logic [7:0] PORT_B_DATA_OFS = 8'h11;
  localparam logic [7:0] PORT_A_DIR_OFS = 8'h14;
  localparam logic [7:0] PORT_B_DIR_OFS = 8'h15;
  localparam logic [7:0] PORT_E_DATA_OFS = 8'h18;
  localparam logic [7:0] PORT_E_DIR_OFS = 8'h1A;
  localparam logic [7:0] PORT_E_PIN_OFS = 8'h1C;
  localparam logic [7:0] PORT_G_DATA_OFS = 8'h20;
  localparam logic [7:0] PORT_H_DATA_OFS = 8'h21;
  localparam logic [7:0] PORT_G_DIR_OFS = 8'h22;
  localparam logic [7:0] PORT_H_DIR_OFS = 8'h23;

  // Port register offsets that always stay internal
  localparam logic [7:0] PORT_C_DATA_OFS = 8'h28;
  localparam logic [7:0] PORT_F_DATA_OFS = 8'h30;
  localparam logic [7:0] PORT_F_DIR_OFS = 8'h32;
  localparam logic [7:0] PORT_F_PIN_OFS = 8'h34;

  // Masked ROM array address range
  localparam logic [23:0] ROM_BASE = 24'h000000;
  localparam logic [23:0] ROM_MASK = 24'hFF8000;

  // Reset-to-run sequencing phases
  typedef enum logic [1:0] {
    PH_RESET = 2'b00,
    PH_MODE  = 2'b01,
    PH_START = 2'b10,
    PH_RUN   = 2'b11
  } phase_t;

  // Decoded operating modes held from reset release
  typedef struct packed {
    logic single_chip;
    logic emulator;
    logic rom_emulation;
    logic rom_select_blocked;
  } mode_t;

  localparam mode_t MODE_RESET = '{1'b0, 1'b0, 1'b0, 1'b0};

endpackage : emu_pkg

// ### mode_if.sv
// Carrier between the top module and its mode latch.
// Assumes both ends share the block clock and reset.
`timescale 1ns/100ps
`default_nettype none
interface mode_if;
  import emu_pkg::*;

  logic sample;
  logic [DATA_W-1:0] data_lvl;
  logic bus_error_lvl;
  logic flash_variant;
  mode_t mode;

  // Latch side: samples pins, returns decoded modes
  modport latch (
    input sample,
    input data_lvl,
    input bus_error_lvl,
    input flash_variant,
    output mode
  );

  // User side: requests the sample and reads modes
  modport user (
    output sample,
    output data_lvl,
    output bus_error_lvl,
    output flash_variant,
    input mode
  );
endinterface : mode_if
`default_nettype wire

// ### mode_latch.sv
// Mode latch: decodes mode pins and holds the result until next reset.
// Assumes the sample request is a one-cycle pulse at reset release.
`timescale 1ns/100ps
`default_nettype none
module mode_latch
  import emu_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Mode carrier
  mode_if.latch mif
);

  typedef struct packed {
    mode_t mode;
  } latch_state_t;

  latch_state_t state_reg;
  latch_state_t state_next;

  logic d_one;
  logic d_ten;
  logic d_thirteen;

  assign d_one = mif.data_lvl[MODE_LINE_ONE_POS];
  assign d_ten = mif.data_lvl[MODE_LINE_TEN_POS];
  assign d_thirteen = mif.data_lvl[MODE_LINE_THIRTEEN_POS];

  // Decode only on the sample pulse; levels are ignored otherwise
  always_comb begin
    state_next = state_reg;
    if (mif.sample) begin
      // [R19] bus error low selects single chip
      state_next.mode.single_chip = ~mif.bus_error_lvl;
      // [R1] emulator mode decode
      state_next.mode.emulator = mif.bus_error_lvl & ~d_ten & ~d_one;
      // [R7] ROM emulation needs line thirteen too
      state_next.mode.rom_emulation = mif.bus_error_lvl & ~d_ten & ~d_one & ~d_thirteen;
      // [R10] flash part cannot drive the ROM select
      state_next.mode.rom_select_blocked = mif.flash_variant & ~d_ten & ~d_one & ~d_thirteen;
    end
  end

  // [R20] modes frozen until the next reset
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_reg <= '{mode: MODE_RESET};
    end else begin
      state_reg <= state_next;
    end
  end

  assign mif.mode = state_reg.mode;

endmodule : mode_latch
`default_nettype wire

// ### emu_reset_pins.sv
// Emulation-mode select logic and reset pin-state control.
// Assumes all pin inputs are synchronous to REF_CLK_IN; pins that are
// two-way are given as output enables, the pad ring resolves them.
//
// Function
// [R1] Emulator mode: line ten, line one low
// [R2] Emulator mode maps listed port registers out
// [R3] Ports C and F stay internal
// [R4] Emulator select asserts at strobe falling edge
// [R5] Mapped-out registers answered by external logic
// [R6] Mapped-out access lasts three clocks
// [R7] ROM emulation: lines one, ten, thirteen low
// [R8] ROM select on valid ROM-range access
// [R9] ROM silent; run external bus cycle
// [R10] Flash part holds ROM select high
// [R11] Module pins become ports, inputs
// [R12] Timer pulse outputs drive; others input
// [R13] Pins idle in reset; mode, then start
// [R14] Outputs operate only after reset release
// [R15] External pulls set input levels
// [R16] Reset: selects high, bus pins floating
// [R17] Release: boot select low, strobes driven
// [R18] Port pins high impedance after reset
// [R19] Bus error low selects single chip
// [R20] Mode pins latched at reset release
`timescale 1ns/100ps
`default_nettype none
module emu_reset_pins
  import emu_pkg::*;
(
  // Clock and block reset
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  // Device reset pin level and mode straps
  input wire logic RESET_N_IN,
  input wire logic [DATA_W-1:0] DATA_IN,
  input wire logic BUS_ERROR_IN,
  input wire logic FLASH_VARIANT_IN,
  // Bus cycle in progress
  input wire logic ADDRESS_STROBE_N_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  // Emulation selects
  output logic EMULATOR_SELECT_N_OUT,
  output logic ROM_EMULATION_SELECT_N_OUT,
  // Bus control towards integration logic
  output logic PORT_RESPOND_OUT,
  output logic PORT_CYCLE_END_OUT,
  output logic ROM_ACK_INHIBIT_OUT,
  output logic EXT_BUS_CYCLE_OUT,
  output logic RESET_EXCEPTION_OUT,
  // Decoded modes
  output logic EMULATOR_MODE_OUT,
  output logic ROM_EMULATION_MODE_OUT,
  output logic SINGLE_CHIP_OUT,
  // Pin states
  output logic [CS_W-1:0] CHIP_SELECT_N_OUT,
  output logic BOOT_SELECT_N_OUT,
  output logic STROBE_RW_OE_OUT,
  output logic ADDR_LOW_OE_OUT,
  output logic DATA_OE_OUT,
  output logic MODULE_PORT_OE_OUT,
  output logic [PWM_W-1:0] TIMER_PULSE_WIDTH_OE_OUT,
  output logic SYSTEM_CLOCK_OUTPUT_EN_OUT,
  output logic DEBUG_PIN_FUNC_OUT
);

  // State of the block, apart from mode outputs and fixed pin drives
  typedef struct packed {
    phase_t phase;
    logic as_prev;
    logic [1:0] port_cnt;
    logic cse_n;
    logic csm_n;
    logic port_respond;
    logic cycle_end;
    logic ext_cycle;
    logic rom_inhibit;
    logic exc_start;
    logic boot_n;
    logic strobe_oe;
    logic addr_oe;
    logic [PWM_W-1:0] pwm_oe;
    logic clk_out_en;
  } top_state_t;

  localparam top_state_t STATE_RESET = '{
    phase: PH_RESET,
    as_prev: 1'b1,
    port_cnt: 2'h0,
    cse_n: 1'b1,
    csm_n: 1'b1,
    port_respond: 1'b0,
    cycle_end: 1'b0,
    ext_cycle: 1'b0,
    rom_inhibit: 1'b0,
    exc_start: 1'b0,
    boot_n: 1'b1,
    strobe_oe: 1'b0,
    addr_oe: 1'b0,
    pwm_oe: 2'h0,
    clk_out_en: 1'b1
  };

  // Port window decode helpers
  function automatic logic in_port_window(input logic [ADDR_W-1:0] a);
    return (a & PORT_WIN_MASK) == PORT_WIN_BASE;
  endfunction : in_port_window

  // [R2] port registers that are mapped out
  function automatic logic is_ext_port(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = a[7:0];
    return in_port_window(a) &&
      (o == PORT_A_DATA_OFS || o == PORT_B_DATA_OFS ||
       o == PORT_A_DIR_OFS || o == PORT_B_DIR_OFS ||
       o == PORT_E_DATA_OFS || o == PORT_E_DIR_OFS ||
       o == PORT_E_PIN_OFS || o == PORT_G_DATA_OFS ||
       o == PORT_H_DATA_OFS || o == PORT_G_DIR_OFS ||
       o == PORT_H_DIR_OFS);
  endfunction : is_ext_port

  // [R3] port registers that always stay internal
  function automatic logic is_int_port(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = a[7:0];
    return in_port_window(a) &&
      (o == PORT_C_DATA_OFS || o == PORT_F_DATA_OFS ||
       o == PORT_F_DIR_OFS || o == PORT_F_PIN_OFS);
  endfunction : is_int_port

  // Reset release synchroniser; second stage feeds the whole design
  logic rst_sync1_reg;
  logic rst_n;

  always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      rst_sync1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_n <= rst_sync1_reg;
    end
  end

  top_state_t state_reg;
  top_state_t state_next;

  // Mode latch hookup
  mode_if mif ();

  mode_latch mode_latch_i (
    .clk_in(REF_CLK_IN),
    .rst_n_in(rst_n),
    .mif(mif)
  );

  assign mif.data_lvl = DATA_IN;
  assign mif.bus_error_lvl = BUS_ERROR_IN;
  assign mif.flash_variant = FLASH_VARIANT_IN;

  // [R20] sample mode pins on the first cycle of release
  assign mif.sample = (state_reg.phase == PH_RESET) && RESET_N_IN;

  logic as_fall;
  logic as_low;
  logic ext_hit;
  logic int_hit;
  logic rom_hit;
  logic running;

  // Cycle qualifiers, only meaningful once running
  assign as_low = ~ADDRESS_STROBE_N_IN;
  assign as_fall = state_reg.as_prev & ~ADDRESS_STROBE_N_IN;
  assign ext_hit = is_ext_port(ADDR_IN);
  assign int_hit = is_int_port(ADDR_IN);
  assign rom_hit = (ADDR_IN & ROM_MASK) == ROM_BASE;
  assign running = (state_reg.phase == PH_RUN);

  // Next-state logic for sequencing, selects and pin states
  always_comb begin
    state_next = state_reg;
    state_next.as_prev = ADDRESS_STROBE_N_IN;
    state_next.cycle_end = 1'b0;
    state_next.exc_start = 1'b0;

    case (state_reg.phase)
      PH_RESET: begin
        if (RESET_N_IN) begin
          state_next.phase = PH_MODE;
        end
      end
      PH_MODE: begin
        // [R13] modes decoded, next start exception
        state_next.phase = PH_START;
      end
      PH_START: begin
        // [R13] reset exception processing begins
        state_next.exc_start = 1'b1;
        state_next.phase = PH_RUN;
      end
      PH_RUN: begin
        state_next.phase = PH_RUN;
      end
      default: begin
        state_next.phase = PH_RESET;
      end
    endcase

    // [R4] emulator select on strobe falling edge
    if (running && mif.mode.emulator && as_fall && ext_hit) begin
      state_next.cse_n = 1'b0;
      state_next.port_cnt = PORT_ACCESS_CYCLES - 2'h1;
    end else if (!state_reg.cse_n) begin
      // [R6] access closes after three clocks, or early if the strobe rises
      if (state_reg.port_cnt == 2'h0 || !as_low) begin
        state_next.cse_n = 1'b1;
        state_next.cycle_end = 1'b1;
      end else begin
        state_next.port_cnt = state_reg.port_cnt - 2'h1;
      end
    end

    // [R5] stay silent on mapped-out registers
    state_next.port_respond = running && as_low &&
      (int_hit || (ext_hit && !mif.mode.emulator));

    // [R8] ROM select on valid ROM access
    state_next.csm_n = ~(running && as_low && rom_hit &&
      mif.mode.rom_emulation && !mif.mode.rom_select_blocked);

    // [R9] ROM silent, external cycle instead
    state_next.rom_inhibit = running && mif.mode.rom_emulation;
    state_next.ext_cycle = running && as_low && rom_hit && mif.mode.rom_emulation;

    // [R16] reset pin states; clock output keeps running
    state_next.clk_out_en = 1'b1;
    if (!running) begin
      state_next.boot_n = 1'b1;
      state_next.strobe_oe = 1'b0;
      state_next.addr_oe = 1'b0;
      // [R14] outputs held off until release
      state_next.pwm_oe = '0;
      state_next.cse_n = 1'b1;
      state_next.csm_n = 1'b1;
      state_next.port_respond = 1'b0;
      state_next.ext_cycle = 1'b0;
    end else begin
      // [R17] boot select low, strobes driven unless single chip
      state_next.boot_n = 1'b0;
      state_next.strobe_oe = ~mif.mode.single_chip;
      state_next.addr_oe = ~mif.mode.single_chip;
      // [R12] timer pulse-width pins become outputs
      state_next.pwm_oe = '1;
    end

    // Device reset pin low again restarts the whole sequence
    if (!RESET_N_IN) begin
      state_next.phase = PH_RESET;
    end
  end

  // Single register stage for all top_state_t fields
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= STATE_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Mode outputs, registered again after the latch
  logic emu_mode_reg;
  logic rom_mode_reg;
  logic single_reg;

  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      emu_mode_reg <= 1'b0;
      rom_mode_reg <= 1'b0;
      single_reg <= 1'b0;
    end else begin
      emu_mode_reg <= mif.mode.emulator;
      rom_mode_reg <= mif.mode.rom_emulation;
      single_reg <= mif.mode.single_chip;
    end
  end

  // Output drive, all from flip-flops
  assign EMULATOR_SELECT_N_OUT = state_reg.cse_n;
  // [R10] select held high on the flash part
  assign ROM_EMULATION_SELECT_N_OUT = state_reg.csm_n;
  assign PORT_RESPOND_OUT = state_reg.port_respond;
  assign PORT_CYCLE_END_OUT = state_reg.cycle_end;
  assign ROM_ACK_INHIBIT_OUT = state_reg.rom_inhibit;
  assign EXT_BUS_CYCLE_OUT = state_reg.ext_cycle;
  assign RESET_EXCEPTION_OUT = state_reg.exc_start;
  assign EMULATOR_MODE_OUT = emu_mode_reg;
  assign ROM_EMULATION_MODE_OUT = rom_mode_reg;
  assign SINGLE_CHIP_OUT = single_reg;

  // [R16] general chip selects stay high throughout
  logic [CS_W-1:0] cs_n_reg;
  logic data_oe_reg;
  logic port_oe_reg;
  logic debug_reg;

  // Data and module port pins are inputs in and out of reset
  always_ff @(posedge REF_CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      cs_n_reg <= '1;
      data_oe_reg <= 1'b0;
      port_oe_reg <= 1'b0;
      debug_reg <= 1'b1;
    end else begin
      cs_n_reg <= '1;
      // [R16] data lines serve as mode inputs
      data_oe_reg <= 1'b0;
      // [R11] [R18] ports as inputs, high impedance
      port_oe_reg <= 1'b0;
      // [R12] debug pins keep debug function
      debug_reg <= 1'b1;
    end
  end

  assign CHIP_SELECT_N_OUT = cs_n_reg;
  assign BOOT_SELECT_N_OUT = state_reg.boot_n;
  assign STROBE_RW_OE_OUT = state_reg.strobe_oe;
  assign ADDR_LOW_OE_OUT = state_reg.addr_oe;
  assign DATA_OE_OUT = data_oe_reg;
  assign MODULE_PORT_OE_OUT = port_oe_reg;
  assign TIMER_PULSE_WIDTH_OE_OUT = state_reg.pwm_oe;
  assign SYSTEM_CLOCK_OUTPUT_EN_OUT = state_reg.clk_out_en;
  assign DEBUG_PIN_FUNC_OUT = debug_reg;

endmodule : emu_reset_pins
`default_nettype wire

// ### emu_reset_pins_props.sv
// Checker for emulation selects and reset pin states.
// Bound to emu_reset_pins; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module emu_reset_pins_props
  import emu_pkg::*;
(
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic ARST_N_IN,
  // Watched inputs
  input wire logic RESET_N_IN,
  input wire logic ADDRESS_STROBE_N_IN,
  input wire logic [ADDR_W-1:0] ADDR_IN,
  // Watched outputs
  input wire logic EMULATOR_SELECT_N_OUT,
  input wire logic ROM_EMULATION_SELECT_N_OUT,
  input wire logic PORT_RESPOND_OUT,
  input wire logic PORT_CYCLE_END_OUT,
  input wire logic EXT_BUS_CYCLE_OUT,
  input wire logic RESET_EXCEPTION_OUT,
  input wire logic EMULATOR_MODE_OUT,
  input wire logic ROM_EMULATION_MODE_OUT,
  input wire logic SINGLE_CHIP_OUT,
  input wire logic [CS_W-1:0] CHIP_SELECT_N_OUT,
  input wire logic BOOT_SELECT_N_OUT,
  input wire logic STROBE_RW_OE_OUT,
  input wire logic ADDR_LOW_OE_OUT,
  input wire logic DATA_OE_OUT,
  input wire logic MODULE_PORT_OE_OUT,
  input wire logic [PWM_W-1:0] TIMER_PULSE_WIDTH_OE_OUT,
  input wire logic SYSTEM_CLOCK_OUTPUT_EN_OUT,
  input wire logic DEBUG_PIN_FUNC_OUT
);
  // One domain, so clock and reset are given once
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  // Select, bus cycle, mode and pin-state relations
  a_select_needs_mode: assert property (!EMULATOR_SELECT_N_OUT |->
    EMULATOR_MODE_OUT && !$past(ADDRESS_STROBE_N_IN)) else $error("select without mode");
  a_select_three_max: assert property (!EMULATOR_SELECT_N_OUT [*3] |=>
    EMULATOR_SELECT_N_OUT) else $error("select held too long");
  a_cycle_end_pulse: assert property (PORT_CYCLE_END_OUT |-> EMULATOR_SELECT_N_OUT &&
    !$past(EMULATOR_SELECT_N_OUT) ##1 !PORT_CYCLE_END_OUT) else $error("bad cycle end");
  a_mapped_silent: assert property (!EMULATOR_SELECT_N_OUT |-> !PORT_RESPOND_OUT)
    else $error("internal answer on mapped register");
  a_rom_select_cause: assert property (!ROM_EMULATION_SELECT_N_OUT |->
    ROM_EMULATION_MODE_OUT && EXT_BUS_CYCLE_OUT && !$past(ADDRESS_STROBE_N_IN) &&
    (($past(ADDR_IN) & ROM_MASK) == ROM_BASE)) else $error("bad ROM select");
  a_chip_selects_high: assert property (CHIP_SELECT_N_OUT == 11'h7FF &&
    SYSTEM_CLOCK_OUTPUT_EN_OUT) else $error("chip select or clock wrong");
  a_reset_pins_idle: assert property (!RESET_N_IN [*3] |-> BOOT_SELECT_N_OUT &&
    !STROBE_RW_OE_OUT && !ADDR_LOW_OE_OUT && TIMER_PULSE_WIDTH_OE_OUT == 2'h0)
    else $error("pins active in reset");
  a_exc_then_boot: assert property (RESET_EXCEPTION_OUT && RESET_N_IN |->
    ##[1:2] !BOOT_SELECT_N_OUT) else $error("boot select late");
  a_modes_held: assert property (!BOOT_SELECT_N_OUT && !$past(BOOT_SELECT_N_OUT) |->
    $stable({EMULATOR_MODE_OUT, ROM_EMULATION_MODE_OUT, SINGLE_CHIP_OUT}))
    else $error("mode changed while running");
  a_single_no_drive: assert property (SINGLE_CHIP_OUT |-> !STROBE_RW_OE_OUT &&
    !ADDR_LOW_OE_OUT && !EMULATOR_MODE_OUT) else $error("single chip drives bus");
  a_ports_stay_inputs: assert property (!DATA_OE_OUT && !MODULE_PORT_OE_OUT &&
    DEBUG_PIN_FUNC_OUT) else $error("port pin driven");

  // Main scenarios reached
  c_port_cycle: cover property (PORT_CYCLE_END_OUT);
  c_rom_select: cover property (!ROM_EMULATION_SELECT_N_OUT);
  c_reset_exc: cover property (RESET_EXCEPTION_OUT);
endmodule : emu_reset_pins_props

bind emu_reset_pins emu_reset_pins_props emu_reset_pins_props_i (.REF_CLK_IN, .ARST_N_IN,
  .RESET_N_IN, .ADDRESS_STROBE_N_IN, .ADDR_IN, .EMULATOR_SELECT_N_OUT,
  .ROM_EMULATION_SELECT_N_OUT, .PORT_RESPOND_OUT, .PORT_CYCLE_END_OUT, .EXT_BUS_CYCLE_OUT,
  .RESET_EXCEPTION_OUT, .EMULATOR_MODE_OUT, .ROM_EMULATION_MODE_OUT, .SINGLE_CHIP_OUT,
  .CHIP_SELECT_N_OUT, .BOOT_SELECT_N_OUT, .STROBE_RW_OE_OUT, .ADDR_LOW_OE_OUT, .DATA_OE_OUT,
  .MODULE_PORT_OE_OUT, .TIMER_PULSE_WIDTH_OE_OUT, .SYSTEM_CLOCK_OUTPUT_EN_OUT,
  .DEBUG_PIN_FUNC_OUT);
`default_nettype wire

// ### port_replacement_model.sv
// External port replacement logic answering mapped-out port cycles.
// Assumes the emulator select is registered on the block clock.
`timescale 1ns/100ps
`default_nettype none
module port_replacement_model #(
  parameter int ANSWER_DELAY = 2
) (
  // Clock and select from the block
  input wire logic clk_in,
  input wire logic select_n_in,
  // Answer given in place of the device
  output logic answer_out
);
  int n;

  always_ff @(posedge clk_in) begin
    if (select_n_in) begin
      n <= 0;
      answer_out <= 1'b0;
    end else begin
      n <= n + 1;
      answer_out <= (n + 1 >= ANSWER_DELAY);
    end
  end
endmodule : port_replacement_model
`default_nettype wire

// ### emu_reset_pins_tb.sv
// Testbench for the emulation-mode and reset-pin block.
// Assumes the checker is bound through its own file.
`timescale 1ns/100ps
`default_nettype none
`define CHECK_EQ(got, exp) begin n_compared++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module emu_reset_pins_tb;
  import emu_pkg::*;
  logic ref_clk, arst_n, reset_n, bus_error, flash, strobe_n, answered;
  logic [15:0] data;
  logic [23:0] addr;
  logic emu_sel_n, rom_sel_n, respond, cycle_end, ack_inh, ext_cyc, exc;
  logic emu_mode, rom_mode, single, boot_n, strobe_oe, addr_oe, data_oe, mport_oe, clk_en, dbg;
  logic [10:0] cs_n;
  logic [1:0] tpw_oe;
  int bad_count, n_compared, cycles, es, rs, ce, pr, pa, xc;
  logic [7:0] mapped[11] = '{PORT_A_DATA_OFS, PORT_B_DATA_OFS, PORT_A_DIR_OFS, PORT_B_DIR_OFS,
    PORT_E_DATA_OFS, PORT_E_DIR_OFS, PORT_E_PIN_OFS, PORT_G_DATA_OFS, PORT_H_DATA_OFS,
    PORT_G_DIR_OFS, PORT_H_DIR_OFS};
  logic [7:0] internal[4] = '{PORT_C_DATA_OFS, PORT_F_DATA_OFS, PORT_F_DIR_OFS, PORT_F_PIN_OFS};

  emu_reset_pins emu_reset_pins_i (.REF_CLK_IN(ref_clk), .ARST_N_IN(arst_n),
    .RESET_N_IN(reset_n), .DATA_IN(data), .BUS_ERROR_IN(bus_error), .FLASH_VARIANT_IN(flash),
    .ADDRESS_STROBE_N_IN(strobe_n), .ADDR_IN(addr), .EMULATOR_SELECT_N_OUT(emu_sel_n),
    .ROM_EMULATION_SELECT_N_OUT(rom_sel_n), .PORT_RESPOND_OUT(respond),
    .PORT_CYCLE_END_OUT(cycle_end), .ROM_ACK_INHIBIT_OUT(ack_inh), .EXT_BUS_CYCLE_OUT(ext_cyc),
    .RESET_EXCEPTION_OUT(exc), .EMULATOR_MODE_OUT(emu_mode), .ROM_EMULATION_MODE_OUT(rom_mode),
    .SINGLE_CHIP_OUT(single), .CHIP_SELECT_N_OUT(cs_n), .BOOT_SELECT_N_OUT(boot_n),
    .STROBE_RW_OE_OUT(strobe_oe), .ADDR_LOW_OE_OUT(addr_oe), .DATA_OE_OUT(data_oe),
    .MODULE_PORT_OE_OUT(mport_oe), .TIMER_PULSE_WIDTH_OE_OUT(tpw_oe),
    .SYSTEM_CLOCK_OUTPUT_EN_OUT(clk_en), .DEBUG_PIN_FUNC_OUT(dbg));
  port_replacement_model port_replacement_model_i (.clk_in(ref_clk), .select_n_in(emu_sel_n),
    .answer_out(answered));

  // 10 MHz clock
  always #50 ref_clk = ~ref_clk;

  // Hang guard; a full run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test

  // Pulse the reset pin, strap the mode lines, check pins both sides of release
  task automatic boot(input logic [15:0] d, input logic be, input logic fl);
    int k;
    @(posedge ref_clk) reset_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHECK_EQ({cs_n, boot_n, clk_en}, 13'h1FFF)
    `CHECK_EQ({strobe_oe, addr_oe, tpw_oe}, 4'h0)
    @(posedge ref_clk);
    data <= d;
    bus_error <= be;
    flash <= fl;
    reset_n <= 1'h1;
    k = 0;
    while (exc !== 1'h1 && k < 20) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    `CHECK_EQ(exc, 1'h1)
    repeat (2) @(posedge ref_clk);
    #1;
    `CHECK_EQ(boot_n, 1'h0)
    `CHECK_EQ({strobe_oe, addr_oe}, {be, be})
    `CHECK_EQ({data_oe, mport_oe, dbg}, 3'h1)
    `CHECK_EQ(tpw_oe, 2'h3)
  endtask : boot

  // One bus cycle with the strobe low for six clocks, counting responses over five
  task automatic bus(input logic [23:0] a);
    {es, rs, ce, pr, pa, xc} = '0;
    @(posedge ref_clk);
    strobe_n <= 1'h0;
    addr <= a;
    repeat (5) begin
      @(posedge ref_clk);
      #1;
      es += (emu_sel_n === 1'h0);
      rs += (rom_sel_n === 1'h0);
      ce += (cycle_end === 1'h1);
      pr += (respond === 1'h1);
      pa += (answered === 1'h1);
      xc += (ext_cyc === 1'h1);
    end
    @(posedge ref_clk) strobe_n <= 1'h1;
    repeat (2) @(posedge ref_clk);
  endtask : bus

  task automatic t_emulator();
    boot(16'hFBFD, 1'h1, 1'h0);
    `CHECK_EQ({emu_mode, rom_mode, single}, 3'h4)
    foreach (mapped[i]) begin
      bus({PORT_WIN_BASE[23:8], mapped[i]});
      `CHECK_EQ(es, 3)
      `CHECK_EQ(ce, 1)
      `CHECK_EQ(pr, 0)
      `CHECK_EQ(pa > 0, 1'h1)
    end
    foreach (internal[i]) begin
      bus({PORT_WIN_BASE[23:8], internal[i]});
      `CHECK_EQ(es, 0)
      `CHECK_EQ(pr > 0, 1'h1)
    end
    bus(24'h000100);
    `CHECK_EQ(rs, 0)
    @(posedge ref_clk);
    data <= 16'hFFFF;
    bus_error <= 1'h0;
    repeat (3) @(posedge ref_clk);
    #1;
    `CHECK_EQ({emu_mode, rom_mode, single}, 3'h4)
  endtask : t_emulator

  task automatic t_rom();
    boot(16'hDBFD, 1'h1, 1'h0);
    `CHECK_EQ({emu_mode, rom_mode, single, ack_inh}, 4'hD)
    bus(24'h000100);
    `CHECK_EQ(rs, 5)
    `CHECK_EQ(xc, 5)
    bus(24'h008000);
    `CHECK_EQ(rs, 0)
  endtask : t_rom

  task automatic t_flash();
    boot(16'hDBFD, 1'h1, 1'h1);
    `CHECK_EQ(rom_mode, 1'h1)
    bus(24'h000100);
    `CHECK_EQ(rs, 0)
  endtask : t_flash

  task automatic t_single();
    boot(16'hDBFD, 1'h0, 1'h0);
    `CHECK_EQ({emu_mode, rom_mode, single}, 3'h1)
    bus({PORT_WIN_BASE[23:8], PORT_A_DATA_OFS});
    `CHECK_EQ(es, 0)
  endtask : t_single

  // Reset, then the scenarios
  initial begin
    {ref_clk, arst_n, reset_n, flash} = '0;
    {bus_error, strobe_n} = 2'h3;
    data = 16'hFFFF;
    addr = 24'h000000;
    repeat (8) @(posedge ref_clk);
    arst_n <= 1'h1;
    repeat (3) @(posedge ref_clk);
    t_emulator();
    t_rom();
    t_flash();
    t_single();
    finish_test();
  end
endmodule : emu_reset_pins_tb
`default_nettype wire
